/* inc/clk_pin_ctrl_pkg.sv */
/*
 * Types of the clock source and clock pin control block.
 * Assumes the register header is compiled alongside.
 */
`default_nettype none

package clk_pin_ctrl_pkg;
    typedef enum logic [1:0] {
        TAP_SYS = 2'h0,
        TAP_PLL = 2'h1,
        TAP_REF = 2'h2,
        TAP_RTC = 2'h3
    } tap_sel_t;
    typedef enum logic [1:0] {
        BOOT_STRAP = 2'h0,
        BOOT_SETUP = 2'h1,
        BOOT_RUN = 2'h2
    } boot_state_t;
endpackage

`default_nettype wire

/* inc/clk_pin_ctrl_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * clock source and clock pin control block.
 * Assumes a 16-bit register port addressed by word offset.
 */
`ifndef CLK_PIN_CTRL_REGS_SVH
`define CLK_PIN_CTRL_REGS_SVH

`define CPC_ADDR_W 16
`define CPC_DATA_W 16
`define CPC_OFS_SLEW 16'h1C16
`define CPC_OFS_DBG_TAP 16'h1C24
`define CPC_OFS_CPU_ST3 16'h1C26
`define CPC_OFS_RTC_PMGT 16'h1930
`define CPC_OFS_WAKE_CTRL 16'h1C28
`define CPC_OFS_STATUS 16'h1C2A
`define CPC_RTC_LO 16'h1900
`define CPC_RTC_HI 16'h197F
`define CPC_TAP_SEL_LSB 0
`define CPC_TAP_SEL_W 2
`define CPC_PIN_OFF_BIT 2
`define CPC_RTCOUT_EN_BIT 0
`define CPC_RTC_OSC_EN_BIT 1
`define CPC_WAKE_OUT_BIT 0
`define CPC_ALARM_BIT 1
`define CPC_SLEW_RST 16'h0000
`define CPC_TAP_SEL_RST 2'h0
`define CPC_STRAP_LAST 2'h3
`define CPC_PMGT_RST 16'h0002
`define CPC_REF_HZ 200000000
`define CPC_CPUDIV_HZ 12000000
`define CPC_SPI_HZ 500000
`define CPC_I2C_HZ 400000
`define CPC_UART_BAUD 57600
`define CPC_SPI_DIV ((`CPC_CPUDIV_HZ / (2 * `CPC_SPI_HZ)))
`define CPC_I2C_DIV ((`CPC_CPUDIV_HZ / (2 * `CPC_I2C_HZ)))
`define CPC_UART_DIV ((`CPC_CPUDIV_HZ / (16 * `CPC_UART_BAUD)))

`endif

/* rtl/clk_pin_ctrl.sv */
/*
 * Clock source selection, debug clock tap, RTC clock output and wake pin.
 * Assumes the candidate clocks arrive as sampled levels on i_clk_sys, the
 * register port is synchronous and the board ties the strap statically.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clk_pin_ctrl_regs.svh"

module clk_pin_ctrl
    import clk_pin_ctrl_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_clk_sel_strap,
    input wire logic i_external_ref_clock_in,
    input wire logic i_rtc_crystal_in,
    input wire logic i_pll_clk,
    input wire logic i_sys_clk,
    input wire logic i_wake_in,
    input wire logic i_rtc_alarm,
    input wire logic [`CPC_ADDR_W-1:0] i_addr,
    input wire logic [`CPC_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`CPC_DATA_W-1:0] o_rdata,
    output logic o_gen_ref_clk,
    output logic o_rtc_timer_clk,
    output logic o_debug_clock_out_pin,
    output logic o_debug_clock_out_oe,
    output logic o_rtc_clock_out_pin,
    output logic o_rtc_clock_out_oe,
    output logic o_wake_out,
    output logic o_wake_oe,
    output logic o_core_wake,
    output logic o_pll_bypass,
    output logic o_rtc_wr,
    output logic [7:0] o_spi_div,
    output logic [7:0] o_i2c_div,
    output logic [7:0] o_uart_div
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] sync_strap;
    logic [1:0] sync_ext;
    logic [1:0] sync_xtal;
    logic [1:0] sync_pll;
    logic [1:0] sync_sys;
    logic [1:0] sync_wake;
    logic [1:0] sync_alarm;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_strap <= 2'h0;
            sync_ext <= 2'h0;
            sync_xtal <= 2'h0;
            sync_pll <= 2'h0;
            sync_sys <= 2'h0;
            sync_wake <= 2'h3;
            sync_alarm <= 2'h0;
        end else begin
            sync_strap <= {sync_strap[0], i_clk_sel_strap};
            sync_ext <= {sync_ext[0], i_external_ref_clock_in};
            sync_xtal <= {sync_xtal[0], i_rtc_crystal_in};
            sync_pll <= {sync_pll[0], i_pll_clk};
            sync_sys <= {sync_sys[0], i_sys_clk};
            sync_wake <= {sync_wake[0], i_wake_in};
            sync_alarm <= {sync_alarm[0], i_rtc_alarm};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture and boot sequence.

    boot_state_t boot_state;
    boot_state_t next_boot_state;
    logic [1:0] strap_wait;
    logic strap_ext;

    always_comb begin
        next_boot_state = boot_state;
        unique case (boot_state)
            BOOT_STRAP: if (strap_wait == `CPC_STRAP_LAST) next_boot_state = BOOT_SETUP;
            BOOT_SETUP: next_boot_state = BOOT_RUN;
            BOOT_RUN: next_boot_state = BOOT_RUN;
            default: next_boot_state = BOOT_STRAP;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_state <= BOOT_STRAP;
            strap_wait <= 2'h0;
            strap_ext <= 1'b0;
        end else begin
            boot_state <= next_boot_state;
            if (boot_state == BOOT_STRAP) begin
                strap_wait <= strap_wait + 2'h1;
                strap_ext <= sync_strap[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [`CPC_DATA_W-1:0] slew_ctrl;
    tap_sel_t tap_source_field;
    logic debug_clock_pin_off;
    logic [`CPC_DATA_W-1:0] rtc_power_mgmt_reg;
    logic wake_out_mode;
    logic alarm_seen;

    function automatic logic addr_is(input logic [`CPC_ADDR_W-1:0] addr, input logic [`CPC_ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    wire logic rtc_clock_out_enable = rtc_power_mgmt_reg[`CPC_RTCOUT_EN_BIT];
    wire logic rtc_osc_on = rtc_power_mgmt_reg[`CPC_RTC_OSC_EN_BIT];
    wire logic in_rtc_range = (i_addr >= `CPC_RTC_LO) && (i_addr <= `CPC_RTC_HI);
    wire logic rtc_blocked = in_rtc_range && !rtc_osc_on;
    wire logic hit_pmgt = addr_is(i_addr, `CPC_OFS_RTC_PMGT);
    wire logic wr_slew = i_wr && addr_is(i_addr, `CPC_OFS_SLEW);
    wire logic wr_tap = i_wr && addr_is(i_addr, `CPC_OFS_DBG_TAP);
    wire logic wr_st3 = i_wr && addr_is(i_addr, `CPC_OFS_CPU_ST3);
    wire logic wr_pmgt = i_wr && hit_pmgt;
    wire logic wr_wake = i_wr && addr_is(i_addr, `CPC_OFS_WAKE_CTRL);
    wire logic rtc_wr_ok = wr_pmgt && !rtc_blocked;
    wire logic boot_setup = (boot_state == BOOT_SETUP);
    wire logic alarm_set = sync_alarm[1];
    wire logic alarm_clr = wr_wake && i_wdata[`CPC_ALARM_BIT];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slew_ctrl <= `CPC_SLEW_RST;
            tap_source_field <= tap_sel_t'(`CPC_TAP_SEL_RST);
            debug_clock_pin_off <= 1'b0;
            rtc_power_mgmt_reg <= `CPC_PMGT_RST;
            wake_out_mode <= 1'b0;
            alarm_seen <= 1'b0;
        end else begin
            if (wr_slew) slew_ctrl <= i_wdata;
            if (wr_tap) tap_source_field <= tap_sel_t'(i_wdata[`CPC_TAP_SEL_LSB +: `CPC_TAP_SEL_W]);
            if (boot_setup) debug_clock_pin_off <= 1'b1;
            else if (wr_st3) debug_clock_pin_off <= i_wdata[`CPC_PIN_OFF_BIT];
            // A write into the closed range is dropped, so once the oscillator is
            // switched off only a reset brings the power register back.
            if (rtc_wr_ok) rtc_power_mgmt_reg <= i_wdata;
            if (wr_wake) wake_out_mode <= i_wdata[`CPC_WAKE_OUT_BIT];
            alarm_seen <= alarm_set | (alarm_seen & ~alarm_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [`CPC_DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (i_addr)
            `CPC_OFS_SLEW: rd_mux = slew_ctrl;
            `CPC_OFS_DBG_TAP: rd_mux = {14'h0000, tap_source_field};
            `CPC_OFS_CPU_ST3: rd_mux = {13'h0000, debug_clock_pin_off, 2'h0};
            `CPC_OFS_RTC_PMGT: rd_mux = rtc_osc_on ? rtc_power_mgmt_reg : 16'h0000;
            `CPC_OFS_WAKE_CTRL: rd_mux = {14'h0000, alarm_seen, wake_out_mode};
            `CPC_OFS_STATUS: rd_mux = {13'h0000, sync_wake[1], o_pll_bypass, strap_ext};
            default: rd_mux = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock routing and pins.

    wire logic gen_ref = strap_ext ? sync_ext[1] : sync_xtal[1];
    wire logic tap_clk = (tap_source_field == TAP_PLL) ? sync_pll[1] :
                         (tap_source_field == TAP_REF) ? gen_ref :
                         (tap_source_field == TAP_RTC) ? sync_xtal[1] : sync_sys[1];

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
            o_gen_ref_clk <= 1'b0;
            o_rtc_timer_clk <= 1'b0;
            o_debug_clock_out_pin <= 1'b0;
            o_debug_clock_out_oe <= 1'b1;
            o_rtc_clock_out_pin <= 1'b0;
            o_rtc_clock_out_oe <= 1'b0;
            o_wake_out <= 1'b1;
            o_wake_oe <= 1'b0;
            o_core_wake <= 1'b0;
            o_pll_bypass <= 1'b0;
            o_rtc_wr <= 1'b0;
            o_spi_div <= 8'h00;
            o_i2c_div <= 8'h00;
            o_uart_div <= 8'h00;
        end else begin
            o_rdata <= (i_rd && !rtc_blocked) ? rd_mux : 16'h0000;
            o_gen_ref_clk <= gen_ref;
            o_rtc_timer_clk <= sync_xtal[1];
            o_debug_clock_out_pin <= tap_clk;
            o_debug_clock_out_oe <= !debug_clock_pin_off;
            o_rtc_clock_out_pin <= sync_xtal[1];
            o_rtc_clock_out_oe <= rtc_clock_out_enable;
            o_wake_out <= 1'b0;
            o_wake_oe <= wake_out_mode && alarm_seen;
            o_core_wake <= !wake_out_mode && !sync_wake[1];
            o_rtc_wr <= rtc_wr_ok;
            if (boot_setup) begin
                o_pll_bypass <= strap_ext;
                o_spi_div <= 8'(`CPC_SPI_DIV);
                o_i2c_div <= 8'(`CPC_I2C_DIV);
                o_uart_div <= 8'(`CPC_UART_DIV);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    AST_DBG_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        boot_setup |=> ##1 !o_debug_clock_out_oe)
        else $error("debug clock pin still driven after boot");

    AST_RTCOE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !rtc_clock_out_enable |=> !o_rtc_clock_out_oe)
        else $error("rtc clock pin driven while disabled");

    AST_BLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_rd && rtc_blocked) |=> (o_rdata == 16'h0000))
        else $error("blocked rtc read returned data");

    AST_STRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (boot_state == BOOT_RUN) |=> $stable(strap_ext))
        else $error("clock source changed while running");

    AST_REF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !strap_ext |=> (o_gen_ref_clk == $past(sync_xtal[1])))
        else $error("generator not fed from oscillator");

    AST_REF_EXT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        strap_ext |=> (o_gen_ref_clk == $past(sync_ext[1])))
        else $error("generator not fed from external input");

    AST_TIMER: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        1'b1 |=> (o_rtc_timer_clk == $past(sync_xtal[1])))
        else $error("rtc timer not fed from oscillator");

    AST_TAP_SYS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (tap_source_field == TAP_SYS) |=> (o_debug_clock_out_pin == $past(sync_sys[1])))
        else $error("debug tap not on system clock");

    AST_TAP_PLL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (tap_source_field == TAP_PLL) |=> (o_debug_clock_out_pin == $past(sync_pll[1])))
        else $error("debug tap not on pll clock");

    AST_TAP_REF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (tap_source_field == TAP_REF) |=> (o_debug_clock_out_pin == $past(gen_ref)))
        else $error("debug tap not on generator reference");

    AST_TAP_RTC: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (tap_source_field == TAP_RTC) |=> (o_debug_clock_out_pin == $past(sync_xtal[1])))
        else $error("debug tap not on oscillator");

    AST_RTC_ON: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        rtc_clock_out_enable |=> o_rtc_clock_out_oe)
        else $error("rtc clock pin floating while enabled");

    AST_RTC_PIN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        1'b1 |=> (o_rtc_clock_out_pin == $past(sync_xtal[1])))
        else $error("rtc clock pin not carrying oscillator");

    AST_DROP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_wr && rtc_blocked) |=> $stable(rtc_power_mgmt_reg))
        else $error("blocked rtc write changed the power register");

    AST_OSC_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_rtc_wr |-> $past(rtc_osc_on))
        else $error("rtc write accepted with oscillator off");

    AST_WAKE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_wake_oe |-> (o_wake_out == 1'b0))
        else $error("wake output not active low");

    AST_WAKE_IN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !wake_out_mode |=> !o_wake_oe)
        else $error("wake pin driven while an input");

    AST_BYPASS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        boot_setup |=> (o_pll_bypass == strap_ext))
        else $error("pll bypass not set by boot");

    AST_DIVS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (boot_state == BOOT_RUN) |-> ((o_spi_div == 8'(`CPC_SPI_DIV)) && (o_i2c_div == 8'(`CPC_I2C_DIV))
        && (o_uart_div == 8'(`CPC_UART_DIV))))
        else $error("boot divisors not loaded");

    AST_CWAKE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (!wake_out_mode && !sync_wake[1]) |=> o_core_wake)
        else $error("wake pin did not wake core");

    AST_RD_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !i_rd |=> (o_rdata == 16'h0000))
        else $error("read data present without a read");

endmodule
`default_nettype wire

/* verif/tb_clk_pin_ctrl.sv */
/*
 * Self-checking bench of the clock source and clock pin control block.
 * Assumes the register header and package are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clk_pin_ctrl_regs.svh"

module tb_clk_pin_ctrl;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_clk_sel_strap = 1'b1;
    logic i_external_ref_clock_in = 1'b0;
    logic i_rtc_crystal_in = 1'b0;
    logic i_pll_clk = 1'b0;
    logic i_sys_clk = 1'b0;
    logic i_wake_in = 1'b1;
    logic i_rtc_alarm = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic o_gen_ref_clk, o_rtc_timer_clk, o_debug_clock_out_pin, o_debug_clock_out_oe;
    logic o_rtc_clock_out_pin, o_rtc_clock_out_oe, o_wake_out, o_wake_oe;
    logic o_core_wake, o_pll_bypass, o_rtc_wr;
    logic [7:0] o_spi_div, o_i2c_div, o_uart_div;
    int err_count = 0;
    int num_checks = 0;
    logic [15:0] d;

    clk_pin_ctrl i_dut (.i_clk_sys, .i_rst_b, .i_clk_sel_strap, .i_external_ref_clock_in,
        .i_rtc_crystal_in, .i_pll_clk, .i_sys_clk, .i_wake_in, .i_rtc_alarm, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .o_gen_ref_clk, .o_rtc_timer_clk, .o_debug_clock_out_pin,
        .o_debug_clock_out_oe, .o_rtc_clock_out_pin, .o_rtc_clock_out_oe, .o_wake_out,
        .o_wake_oe, .o_core_wake, .o_pll_bypass, .o_rtc_wr, .o_spi_div, .o_i2c_div, .o_uart_div);

    always #2.5 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic do_reset(input logic s);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b0;
        i_clk_sel_strap <= s;
        cyc(11);
        chk(o_debug_clock_out_oe, 1'b1);
        chk(o_rtc_clock_out_oe, 1'b0);
        chk(o_wake_oe, 1'b0);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        #1;
        chk(o_spi_div, 8'h00);
    endtask

    // Boot must float the debug pin within a few cycles of reset release.
    task automatic wait_boot();
        int k;
        k = 0;
        while (o_debug_clock_out_oe !== 1'b0 && k < 20) begin
            cyc(1);
            k++;
        end
        chk(k < 20, 1'b1);
        if (k >= 20) begin
            finish_test();
        end
    endtask

    task automatic drive(input logic [3:0] v);
        @(posedge i_clk_sys);
        {i_rtc_crystal_in, i_external_ref_clock_in, i_pll_clk, i_sys_clk} <= v;
        cyc(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_boot();
        wait_boot();
        chk({o_spi_div, o_i2c_div}, 16'h0C0F);
        chk(o_uart_div, 8'h0D);
        chk(o_pll_bypass, 1'b1);
        rd(`CPC_OFS_STATUS);
        chk(d, 16'h0007);
        cyc(1);
        chk(o_rdata, 16'h0000);
        rd(`CPC_OFS_CPU_ST3);
        chk(d & 16'h0004, 16'h0004);
        rd(`CPC_OFS_RTC_PMGT);
        chk(d, `CPC_PMGT_RST);
        wr(`CPC_OFS_SLEW, 16'hA5C3);
        wr(16'h1C3E, 16'hFFFF);
        rd(`CPC_OFS_SLEW);
        chk(d, 16'hA5C3);
        rd(16'h1C3E);
        chk(d, 16'h0000);
        $display("boot test done");
    endtask

    task automatic test_route();
        drive(4'h4);
        chk({o_gen_ref_clk, o_rtc_timer_clk}, 2'h2);
        drive(4'h8);
        chk({o_gen_ref_clk, o_rtc_timer_clk}, 2'h1);
        @(posedge i_clk_sys);
        i_clk_sel_strap <= 1'b0;
        drive(4'h4);
        chk({o_gen_ref_clk, o_pll_bypass}, 2'h3);
        do_reset(1'b0);
        drive(4'h8);
        chk({o_gen_ref_clk, o_rtc_timer_clk}, 2'h3);
        drive(4'h4);
        chk(o_gen_ref_clk, 1'b0);
        wait_boot();
        chk(o_pll_bypass, 1'b0);
        rd(`CPC_OFS_STATUS);
        chk(d, 16'h0004);
        $display("route test done");
    endtask

    task automatic test_tap();
        wr(`CPC_OFS_CPU_ST3, 16'h0000);
        cyc(3);
        chk(o_debug_clock_out_oe, 1'b1);
        for (int s = 0; s < 4; s++) begin
            wr(`CPC_OFS_DBG_TAP, 16'(s));
            rd(`CPC_OFS_DBG_TAP);
            chk(d & 16'h0003, 16'(s));
            drive(4'h1 << s);
            chk(o_debug_clock_out_pin, 1'b1);
            drive(~(4'h1 << s));
            chk(o_debug_clock_out_pin, 1'b0);
        end
        wr(`CPC_OFS_CPU_ST3, 16'h0004);
        cyc(3);
        chk(o_debug_clock_out_oe, 1'b0);
        $display("tap test done");
    endtask

    task automatic test_rtc();
        wr(`CPC_OFS_RTC_PMGT, 16'h0003);
        chk(o_rtc_wr, 1'b1);
        cyc(1);
        chk(o_rtc_clock_out_oe, 1'b1);
        drive(4'h8);
        chk(o_rtc_clock_out_pin, 1'b1);
        wr(`CPC_OFS_RTC_PMGT, 16'h0001);
        rd(`CPC_OFS_RTC_PMGT);
        chk(d, 16'h0000);
        wr(`CPC_OFS_RTC_PMGT, 16'h0002);
        chk(o_rtc_wr, 1'b0);
        cyc(2);
        chk(o_rtc_clock_out_oe, 1'b1);
        rd(`CPC_RTC_HI);
        chk(d, 16'h0000);
        wr(`CPC_OFS_SLEW, 16'h5A3C);
        rd(`CPC_OFS_SLEW);
        chk(d, 16'h5A3C);
        $display("rtc test done");
    endtask

    task automatic test_wake();
        @(posedge i_clk_sys);
        i_wake_in <= 1'b0;
        cyc(4);
        chk({o_core_wake, o_wake_oe}, 2'h2);
        @(posedge i_clk_sys);
        i_wake_in <= 1'b1;
        wr(`CPC_OFS_WAKE_CTRL, 16'h0001);
        @(posedge i_clk_sys);
        i_rtc_alarm <= 1'b1;
        cyc(4);
        chk({o_wake_oe, o_wake_out}, 2'h2);
        @(posedge i_clk_sys);
        i_rtc_alarm <= 1'b0;
        cyc(4);
        chk(o_wake_oe, 1'b1);
        wr(`CPC_OFS_WAKE_CTRL, 16'h0003);
        cyc(2);
        chk(o_wake_oe, 1'b0);
        $display("wake test done");
    endtask

    initial begin
        do_reset(1'b1);
        chk(o_debug_clock_out_oe, 1'b1);
        test_boot();
        test_tap();
        test_wake();
        test_route();
        test_rtc();
        finish_test();
    end
endmodule
`default_nettype wire
